// ---- pkg/kpi_pkg.sv ----
// package for the pin event unit: widths, reset values, carrier types
// assumes nothing beyond a synthesizable SystemVerilog tool flow
package kpi_pkg;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int          KPI_NUM_PINS  = 8;
  localparam logic [7:0]  KPI_PE_RST    = 8'h00;
  localparam logic [7:0]  KPI_POL_RST   = 8'h00;
  localparam logic        KPI_BIT_RST   = 1'b0;
  localparam logic        KPI_MODE_EDGE = 1'b0;
  localparam logic        KPI_MODE_LVL  = 1'b1;
  localparam logic        KPI_POL_LOW   = 1'b0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [KPI_NUM_PINS-1:0] pin_enable_bit;
    logic [KPI_NUM_PINS-1:0] polarity_select_bit;
    logic                    detect_mode_bit;
    logic                    irq_enable_bit;
  } kpi_cfg_t;

  typedef struct packed {
    logic event_flag;
    logic irq;
    logic wake;
  } kpi_stat_t;

endpackage : kpi_pkg

// ---- src/kpi_sense.sv ----
// per-pin sense stage: normalise polarity, mask, find edges
// assumes pins are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module kpi_sense #(
  parameter int N = kpi_pkg::KPI_NUM_PINS
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // pins and settings
  input  wire logic [N-1:0] pins,
  input  wire logic [N-1:0] enable,
  input  wire logic [N-1:0] polarity,
  // results
  output logic      [N-1:0] asserted,
  output logic      [N-1:0] edge_seen
);
  import kpi_pkg::*;

  logic [N-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      // 0 = low asserted, 1 = high asserted
      assign asserted[g] = enable[g] & (pins[g] ^ (polarity[g] == KPI_POL_LOW));
      // deasserted last cycle, asserted this cycle
      assign edge_seen[g] = asserted[g] & ~prev_reg[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // history; reset treats every pin as asserted so no edge is pending
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= asserted;
    end
  end

endmodule : kpi_sense
`default_nettype wire

// ---- src/kpi_flag.sv ----
// sticky event flag with acknowledge and level-mode clear guard
// assumes acknowledge is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`default_nettype none
module kpi_flag (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // causes
  input  wire logic set_evt,
  input  wire logic ack,
  input  wire logic any_asserted,
  input  wire logic level_mode,
  // state
  output logic      flag
);
  import kpi_pkg::*;

  logic flag_reg;
  logic flag_next;
  wire  clear_ok = ack & ~(level_mode & any_asserted);

  // set wins over clear
  assign flag_next = set_evt | (flag_reg & ~clear_ok);
  assign flag      = flag_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_reg <= KPI_BIT_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule : kpi_flag
`default_nettype wire

// ---- src/kpi_pin_event_unit.sv ----
// pin event unit top: eight pin interrupt detector with sticky flag
// assumes settings are plain ports driven synchronously to ref_clk
`timescale 1ns/1ps
`default_nettype none
module kpi_pin_event_unit #(
  parameter int N = kpi_pkg::KPI_NUM_PINS
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // pins
  input  wire logic [N-1:0]     pins,
  // settings, all loaded by the one write strobe cfg_we with data, plus the flag acknowledge
  input  wire logic             cfg_we,
  input  wire logic [N-1:0]     pin_enable_bit,
  input  wire logic [N-1:0]     polarity_select_bit,
  input  wire logic             detect_mode_bit,
  input  wire logic             irq_enable_bit,
  input  wire logic             flag_ack_bit,
  // state
  output logic      [N-1:0]     pin_enable_q,
  output logic      [N-1:0]     polarity_q,
  output logic                  detect_mode_q,
  output logic                  irq_enable_q,
  output logic                  event_flag,
  output logic                  irq,
  output logic                  wake
);
  import kpi_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // mode decode for the set path and the clear guard
  function automatic logic kpi_is_level(input logic mode);
    return mode == KPI_MODE_LVL;
  endfunction : kpi_is_level

  localparam kpi_cfg_t KPI_CFG_RST = '{
    pin_enable_bit:      KPI_PE_RST,
    polarity_select_bit: KPI_POL_RST,
    detect_mode_bit:     KPI_MODE_EDGE,
    irq_enable_bit:      KPI_BIT_RST
  };

  localparam kpi_stat_t KPI_STAT_RST = '{
    event_flag: KPI_BIT_RST,
    irq:        KPI_BIT_RST,
    wake:       KPI_BIT_RST
  };

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  kpi_cfg_t     cfg_wr;
  kpi_cfg_t     cfg_reg;
  kpi_cfg_t     cfg_next;
  logic [N-1:0] pe_reg;
  logic [N-1:0] pol_reg;
  logic         mode_reg;
  logic         ie_reg;

  assign cfg_wr.pin_enable_bit      = KPI_NUM_PINS'(pin_enable_bit);
  assign cfg_wr.polarity_select_bit = KPI_NUM_PINS'(polarity_select_bit);
  assign cfg_wr.detect_mode_bit     = detect_mode_bit;
  assign cfg_wr.irq_enable_bit      = irq_enable_bit;
  assign cfg_next                   = cfg_we ? cfg_wr : cfg_reg;

  assign pe_reg   = cfg_reg.pin_enable_bit[N-1:0];
  assign pol_reg  = cfg_reg.polarity_select_bit[N-1:0];
  assign mode_reg = cfg_reg.detect_mode_bit;
  assign ie_reg   = cfg_reg.irq_enable_bit;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_reg <= KPI_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  logic [N-1:0] asserted;
  logic [N-1:0] edge_seen;
  logic         armed_reg;
  logic         flag;

  kpi_sense #(.N(N)) u_sense (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .pins      (pins),
    .enable    (pe_reg),
    .polarity  (pol_reg),
    .asserted  (asserted),
    .edge_seen (edge_seen)
  );

  wire any_asserted = |asserted;
  wire any_edge     = armed_reg & (|edge_seen);
  wire level_mode   = kpi_is_level(mode_reg);
  wire set_evt      = any_edge | (level_mode & any_asserted);

  // lockout until every enabled pin is deasserted again
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      armed_reg <= KPI_BIT_RST;
    end else if (!any_asserted) begin
      armed_reg <= 1'b1;
    end else if (any_edge) begin
      armed_reg <= 1'b0;
    end
  end

  kpi_flag u_flag (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .set_evt      (set_evt),
    .ack          (flag_ack_bit),
    .any_asserted (any_asserted),
    .level_mode   (level_mode),
    .flag         (flag)
  );

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  kpi_stat_t stat_next;
  kpi_stat_t stat_reg;

  assign stat_next.event_flag = flag;
  assign stat_next.irq        = flag & ie_reg;
  assign stat_next.wake       = flag & ie_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_enable_q  <= KPI_PE_RST[N-1:0];
      polarity_q    <= KPI_POL_RST[N-1:0];
      detect_mode_q <= KPI_MODE_EDGE;
      irq_enable_q  <= KPI_BIT_RST;
      stat_reg      <= KPI_STAT_RST;
    end else begin
      pin_enable_q  <= pe_reg;
      polarity_q    <= pol_reg;
      detect_mode_q <= mode_reg;
      irq_enable_q  <= ie_reg;
      stat_reg      <= stat_next;
    end
  end

  assign event_flag = stat_reg.event_flag;
  assign irq        = stat_reg.irq;
  assign wake       = stat_reg.wake;

endmodule : kpi_pin_event_unit
`default_nettype wire

// ---- verif/kpi_chk.sv ----
// checker on the pin event unit ports
// assumes binding into kpi_pin_event_unit
`timescale 1ns/1ps
`default_nettype none
module kpi_chk #(parameter int N = 8) (
  input wire logic         ref_clk, srst, cfg_we, detect_mode_bit, irq_enable_bit,
  input wire logic         flag_ack_bit, detect_mode_q, irq_enable_q, event_flag, irq, wake,
  input wire logic [N-1:0] pins, pin_enable_bit, polarity_select_bit, pin_enable_q, polarity_q
);
  wire logic asrt = |(pin_enable_q & ~(pins ^ polarity_q));
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_cfg_load: assert property (cfg_we |-> ##2 pin_enable_q == $past(pin_enable_bit, 2)
    && irq_enable_q == $past(irq_enable_bit, 2)) else $error("bad enables");
  a_mode_load: assert property (cfg_we |-> ##2 detect_mode_q == $past(detect_mode_bit, 2)
    && polarity_q == $past(polarity_select_bit, 2)) else $error("bad mode");
  a_irq_match: assert property (irq == (event_flag & irq_enable_q)) else $error("bad irq");
  a_wake_match: assert property (wake == irq) else $error("bad wake");
  a_flag_cause: assert property ($rose(event_flag) |-> $past(asrt, 2)) else $error("bad set");
  a_flag_hold: assert property (event_flag && !flag_ack_bit && !$past(flag_ack_bit)
    |=> event_flag) else $error("flag lost");
  a_ack_edge: assert property (flag_ack_bit && !detect_mode_q |-> ##2 !event_flag)
    else $error("ack ignored");
  a_ack_level: assert property (flag_ack_bit && detect_mode_q && asrt |-> ##2 event_flag)
    else $error("flag cleared");
  a_reset_clear: assert property ($fell(srst) |-> !event_flag && pin_enable_q == '0)
    else $error("reset left state");
  c_flag: cover property ($rose(event_flag));
  c_level_hold: cover property (flag_ack_bit && detect_mode_q && asrt);
  c_irq: cover property ($rose(irq));
endmodule : kpi_chk
bind kpi_pin_event_unit kpi_chk #(.N(N)) u_chk (.*);
`default_nettype wire

// ---- verif/kpi_pin_src.sv ----
// switches on the pins, moved at the falling clock edge
// assumes the bench names the level it wants
`timescale 1ns/1ps
`default_nettype none
module kpi_pin_src (
  input  wire logic       ref_clk,
  input  wire logic [7:0] want,
  output var  logic [7:0] pins
);
  initial pins = 8'hff;
  always @(negedge ref_clk) pins <= want;
endmodule : kpi_pin_src
`default_nettype wire

// ---- verif/tb_top.sv ----
// bench: random pin and polarity rounds in both modes, queue scoreboard
// assumes kpi_pkg, kpi_pin_src and kpi_chk compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 0, srst = 1, cfg_we = 0, flag_ack_bit = 0, look = 0;
  logic detect_mode_bit = 0, irq_enable_bit = 0, detect_mode_q, irq_enable_q;
  logic [7:0] want = 8'hff, pin_enable_bit = 0, polarity_select_bit = 0, p;
  logic [7:0] pins, pin_enable_q, polarity_q;
  logic event_flag, irq, wake;
  logic [20:0] got, q[$];
  int fails = 0, compares = 0, k, j;
  kpi_pin_src u_src (.ref_clk(ref_clk), .want(want), .pins(pins));
  kpi_pin_event_unit dut (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic step(int n);
    repeat (n) @(negedge ref_clk);
  endtask : step
  task automatic cfg(logic [7:0] e, logic m, logic i);
    pin_enable_bit = e; polarity_select_bit = p; detect_mode_bit = m; irq_enable_bit = i;
    cfg_we = 1;
    step(1);
    cfg_we = 0;
    step(2);
  endtask : cfg
  task automatic ackp;
    flag_ack_bit = 1;
    step(1);
    flag_ack_bit = 0;
    step(3);
  endtask : ackp
  task automatic chk(logic f);
    q.push_back({pin_enable_bit, polarity_select_bit, detect_mode_bit, irq_enable_bit,
                 f, {2{f & irq_enable_bit}}});
    look <= 1;
    step(1);
    look <= 0;
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(negedge ref_clk) begin
    if (look) begin
      got = {pin_enable_q, polarity_q, detect_mode_q, irq_enable_q, event_flag, irq, wake};
      compares++;
      if (got !== q.pop_front()) begin
        fails++;
        $display("wrong value at %0t: outputs %h", $time, got);
      end
    end
  end
  initial begin
    k = $urandom(32'h557d7120);
    step(3);
    srst = 0;
    step(1);
    chk(0);
    for (int m = 0; m < 2; m++) begin
      for (int r = 0; r < 4; r++) begin
        k = $urandom_range(7);
        j = (k + 1 + $urandom_range(6)) % 8;
        p = 8'($urandom);
        want <= ~p;
        cfg(8'h00, m[0], 1'b0);
        cfg(8'h01 << k, m[0], r[0]);
        ackp();
        want <= ~p ^ (8'h01 << j);
        step(3);
        chk(0);
        want <= ~p ^ (8'h01 << k);
        step(3);
        chk(1);
        ackp();
        chk(m[0]);
        cfg((8'h01 << k) | (8'h01 << j), m[0], r[0]);
        want <= ~p ^ (8'h01 << k) ^ (8'h01 << j);
        step(3);
        chk(m[0]);
        want <= ~p;
        step(2);
        ackp();
        chk(0);
        want <= ~p ^ (8'h01 << k);
        step(3);
        chk(1);
        want <= ~p;
        step(2);
        ackp();
        $display("round %0d mode %0d done", r, m);
      end
    end
    tally_and_finish();
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
